//--- hw/pabm_cfg.svh
// Constants for the port A/B alternate function mux: widths and pin positions.
// Assumes inclusion by bare name from hw/.
`ifndef PABM_CFG_SVH
`define PABM_CFG_SVH
`define PABM_PORT_W     8
`define PABM_LCD_LO     0
`define PABM_LCD_HI     3
`define PABM_SEG_LO     4
`define PABM_SEG_HI     7
`define PABM_PIN_SS     0
`define PABM_PIN_SCK    1
`define PABM_PIN_MOSI   2
`define PABM_PIN_MISO   3
`define PABM_PIN_T0A    4
`define PABM_PIN_T1A    5
`define PABM_PIN_T1B    6
`define PABM_PIN_T2A    7
`define PABM_PCINT_BASE 8
`define PABM_PU_PATTERN 3'b010
`endif

//--- hw/pabm_pkg.sv
// Types shared by the port A/B alternate function mux.
// Assumes pabm_cfg.svh sits beside it.
`include "pabm_cfg.svh"
package pabm_pkg;
    typedef logic [`PABM_PORT_W-1:0] pabm_port_t;
    typedef enum logic [1:0] {
        PABM_SPI_OFF    = 2'b00,
        PABM_SPI_SLAVE  = 2'b01,
        PABM_SPI_MASTER = 2'b11
    } pabm_spi_mode_t;
endpackage

//--- hw/pabm_pad_ctl.sv
// One pad's resolution of override signals against port register bits.
// Assumes the caller supplies override enables and values combinationally.
`timescale 1ns/1ps
`include "pabm_cfg.svh"
module pabm_pad_ctl (
    input  wire logic dir_bit,
    input  wire logic out_bit,
    input  wire logic pull_disable,
    input  wire logic sleeping,
    input  wire logic pullup_ovr_en,
    input  wire logic pullup_ovr_val,
    input  wire logic dir_ovr_en,
    input  wire logic dir_ovr_val,
    input  wire logic outval_ovr_en,
    input  wire logic outval_ovr_val,
    input  wire logic inen_ovr_en,
    input  wire logic inen_ovr_val,
    output logic      pull_en,
    output logic      drive_en,
    output logic      drive_val,
    output logic      in_en
);
    // Pad resolution
    always_comb begin
        pull_en   = pullup_ovr_en ? pullup_ovr_val
                  : ({dir_bit, out_bit, pull_disable} == `PABM_PU_PATTERN);
        drive_en  = dir_ovr_en ? dir_ovr_val : dir_bit;
        drive_val = (outval_ovr_en && drive_en) ? outval_ovr_val : out_bit;
        in_en     = inen_ovr_en ? inen_ovr_val : !sleeping;
    end
endmodule

//--- hw/pabm_mux.sv
// Alternate function override mux for two 8-bit ports: display lines on the
// first port, timer outputs, SPI forcing and pin-change sources on the second.
// Assumes peripheral enables are synchronous to clock; pads resolve the rest.
//
// Contract
// - First port: upper four pins frontplanes 3..0, lower four backplanes 3..0.
// - Frontplane pins: pull, direction, input overrides follow display enable; values zero.
// - Backplane 0 uses enable alone; backplanes 3..1 also need the count qualifier.
// - Second port pin 7 drives timer-2 compare A when its direction bit set.
// - Pin 6 drives timer-1 compare B when its direction bit set.
// - Pin 5 drives timer-1 compare A when its direction bit set.
// - Pin 4 drives timer-0 compare A when its direction bit set.
// - SPI master forces pin 3 input, pull from output bit; slave uses direction.
// - SPI slave forces pin 2 input, pull from output bit; master uses direction.
// - SPI slave forces pin 1 input, pull from output bit; master uses direction.
// - Second port pins 7..0 feed pin-change sources 15..8.
// - Pin 0 is the SPI slave-select input as well as a pin-change source.
// - Pull-up follows override value, else enabled on pattern 010.
// - Direction override sets the driver, else the direction bit does.
// - Output value override replaces port bit while driver enabled.
// - Input enable override wins over sleep state.
`timescale 1ns/1ps
`include "pabm_cfg.svh"
module pabm_mux (
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     display_drive_enable,
    input  wire logic [3:1]               backplane_count_qualifier,
    input  wire logic                     pull_disable,
    input  wire logic                     sleeping,
    input  wire logic [7:0]               porta_dir,
    input  wire logic [7:0]               porta_out,
    input  wire logic [7:0]               portb_dir,
    input  wire logic [7:0]               portb_out,
    input  wire logic                     t2_compare_a_en,
    input  wire logic                     t2_compare_a_out,
    input  wire logic                     t1_compare_b_en,
    input  wire logic                     t1_compare_b_out,
    input  wire logic                     t1_compare_a_en,
    input  wire logic                     t1_compare_a_out,
    input  wire logic                     t0_compare_a_en,
    input  wire logic                     t0_compare_a_out,
    input  wire logic                     spi_enable,
    input  wire logic                     spi_master,
    input  wire logic                     spi_slave_out,
    input  wire logic                     spi_master_out,
    input  wire logic                     spi_sck_out,
    input  wire logic [7:0]               pin_change_mask,
    input  wire logic                     pin_change_group_en,
    input  wire logic [7:0]               porta_pad_in,
    input  wire logic [7:0]               portb_pad_in,
    output logic      [7:0]               porta_pull_en,
    output logic      [7:0]               porta_drive_en,
    output logic      [7:0]               porta_drive_val,
    output logic      [7:0]               porta_in_en,
    output logic      [3:0]               segment_analog_path,
    output logic      [3:0]               backplane_analog_path,
    output logic      [7:0]               portb_pull_en,
    output logic      [7:0]               portb_drive_en,
    output logic      [7:0]               portb_drive_val,
    output logic      [7:0]               portb_in_en,
    output logic      [15:8]              pin_change_source,
    output logic                          spi_ss_in,
    output logic                          spi_sck_in,
    output logic                          spi_slave_in,
    output logic                          spi_master_in,
    output pabm_pkg::pabm_spi_mode_t      spi_mode
);
    //--------------------------------------------------------------
    // Override computation
    //--------------------------------------------------------------
    logic [7:0] a_pullup_ovr_en, a_pullup_ovr_val, a_dir_ovr_en, a_dir_ovr_val;
    logic [7:0] a_outval_ovr_en, a_outval_ovr_val, a_inen_ovr_en, a_inen_ovr_val;
    logic [7:0] b_pullup_ovr_en, b_pullup_ovr_val, b_dir_ovr_en, b_dir_ovr_val;
    logic [7:0] b_outval_ovr_en, b_outval_ovr_val, b_inen_ovr_en, b_inen_ovr_val;
    logic       spi_is_master;
    logic       spi_is_slave;
    pabm_pkg::pabm_spi_mode_t next_spi_mode;

    // SPI role decode, no clock delay
    always_comb begin
        spi_is_master = spi_enable && spi_master;
        spi_is_slave  = spi_enable && !spi_master;
    end

    // First port overrides: display lines only
    always_comb begin
        a_pullup_ovr_val = 8'h00;
        a_dir_ovr_val    = 8'h00;
        a_outval_ovr_en  = 8'h00;
        a_outval_ovr_val = 8'h00;
        a_inen_ovr_val   = 8'h00;
        for (int i = `PABM_SEG_LO; i <= `PABM_SEG_HI; i++) begin
            a_pullup_ovr_en[i] = display_drive_enable;
            a_dir_ovr_en[i]    = display_drive_enable;
            a_inen_ovr_en[i]   = display_drive_enable;
        end
        a_pullup_ovr_en[0] = display_drive_enable;
        a_dir_ovr_en[0]    = display_drive_enable;
        a_inen_ovr_en[0]   = display_drive_enable;
        for (int i = 1; i <= `PABM_LCD_HI; i++) begin
            a_pullup_ovr_en[i] = display_drive_enable && backplane_count_qualifier[i];
            a_dir_ovr_en[i]    = display_drive_enable && backplane_count_qualifier[i];
            a_inen_ovr_en[i]   = display_drive_enable && backplane_count_qualifier[i];
        end
    end

    // Second port overrides: timers, SPI, pin change
    always_comb begin
        b_pullup_ovr_en  = 8'h00;
        b_pullup_ovr_val = 8'h00;
        b_dir_ovr_en     = 8'h00;
        b_dir_ovr_val    = 8'h00;
        b_outval_ovr_en  = 8'h00;
        b_outval_ovr_val = 8'h00;
        // Timer outputs reach the pin only through the direction bit
        b_outval_ovr_en[`PABM_PIN_T2A]  = t2_compare_a_en;
        b_outval_ovr_val[`PABM_PIN_T2A] = t2_compare_a_out;
        b_outval_ovr_en[`PABM_PIN_T1B]  = t1_compare_b_en;
        b_outval_ovr_val[`PABM_PIN_T1B] = t1_compare_b_out;
        b_outval_ovr_en[`PABM_PIN_T1A]  = t1_compare_a_en;
        b_outval_ovr_val[`PABM_PIN_T1A] = t1_compare_a_out;
        b_outval_ovr_en[`PABM_PIN_T0A]  = t0_compare_a_en;
        b_outval_ovr_val[`PABM_PIN_T0A] = t0_compare_a_out;
        // Input forcing; pull kept as if direction were input
        if (spi_is_master) begin
            b_pullup_ovr_en[`PABM_PIN_MISO]  = 1'b1;
            b_pullup_ovr_val[`PABM_PIN_MISO] = portb_out[`PABM_PIN_MISO] && !pull_disable;
            b_dir_ovr_en[`PABM_PIN_MISO]     = 1'b1;
            b_outval_ovr_en[`PABM_PIN_MOSI]  = 1'b1;
            b_outval_ovr_val[`PABM_PIN_MOSI] = spi_master_out;
            b_outval_ovr_en[`PABM_PIN_SCK]   = 1'b1;
            b_outval_ovr_val[`PABM_PIN_SCK]  = spi_sck_out;
        end
        if (spi_is_slave) begin
            b_outval_ovr_en[`PABM_PIN_MISO]  = 1'b1;
            b_outval_ovr_val[`PABM_PIN_MISO] = spi_slave_out;
            b_pullup_ovr_en[`PABM_PIN_MOSI]  = 1'b1;
            b_pullup_ovr_val[`PABM_PIN_MOSI] = portb_out[`PABM_PIN_MOSI] && !pull_disable;
            b_dir_ovr_en[`PABM_PIN_MOSI]     = 1'b1;
            b_pullup_ovr_en[`PABM_PIN_SCK]   = 1'b1;
            b_pullup_ovr_val[`PABM_PIN_SCK]  = portb_out[`PABM_PIN_SCK] && !pull_disable;
            b_dir_ovr_en[`PABM_PIN_SCK]      = 1'b1;
            b_pullup_ovr_en[`PABM_PIN_SS]    = 1'b1;
            b_pullup_ovr_val[`PABM_PIN_SS]   = portb_out[`PABM_PIN_SS] && !pull_disable;
            b_dir_ovr_en[`PABM_PIN_SS]       = 1'b1;
        end
        // Enabled pin-change sources keep their input buffer alive in sleep
        b_inen_ovr_en  = pin_change_mask & {8{pin_change_group_en}};
        b_inen_ovr_val = 8'hff;
    end

    //--------------------------------------------------------------
    // Pad resolution per pin
    //--------------------------------------------------------------
    for (genvar g = 0; g < `PABM_PORT_W; g++) begin : g_pin
        pabm_pad_ctl u_a (
            .dir_bit        (porta_dir[g]),
            .out_bit        (porta_out[g]),
            .pull_disable   (pull_disable),
            .sleeping       (sleeping),
            .pullup_ovr_en  (a_pullup_ovr_en[g]),
            .pullup_ovr_val (a_pullup_ovr_val[g]),
            .dir_ovr_en     (a_dir_ovr_en[g]),
            .dir_ovr_val    (a_dir_ovr_val[g]),
            .outval_ovr_en  (a_outval_ovr_en[g]),
            .outval_ovr_val (a_outval_ovr_val[g]),
            .inen_ovr_en    (a_inen_ovr_en[g]),
            .inen_ovr_val   (a_inen_ovr_val[g]),
            .pull_en        (porta_pull_en[g]),
            .drive_en       (porta_drive_en[g]),
            .drive_val      (porta_drive_val[g]),
            .in_en          (porta_in_en[g])
        );
        pabm_pad_ctl u_b (
            .dir_bit        (portb_dir[g]),
            .out_bit        (portb_out[g]),
            .pull_disable   (pull_disable),
            .sleeping       (sleeping),
            .pullup_ovr_en  (b_pullup_ovr_en[g]),
            .pullup_ovr_val (b_pullup_ovr_val[g]),
            .dir_ovr_en     (b_dir_ovr_en[g]),
            .dir_ovr_val    (b_dir_ovr_val[g]),
            .outval_ovr_en  (b_outval_ovr_en[g]),
            .outval_ovr_val (b_outval_ovr_val[g]),
            .inen_ovr_en    (b_inen_ovr_en[g]),
            .inen_ovr_val   (b_inen_ovr_val[g]),
            .pull_en        (portb_pull_en[g]),
            .drive_en       (portb_drive_en[g]),
            .drive_val      (portb_drive_val[g]),
            .in_en          (portb_in_en[g])
        );
    end

    //--------------------------------------------------------------
    // Inputs to peripherals and display analog paths
    //--------------------------------------------------------------
    // Pad levels passed straight to peripherals, no added delay
    always_comb begin
        segment_analog_path   = porta_pad_in[`PABM_SEG_HI:`PABM_SEG_LO];
        backplane_analog_path = porta_pad_in[`PABM_LCD_HI:`PABM_LCD_LO];
        pin_change_source     = portb_pad_in;
        spi_ss_in             = portb_pad_in[`PABM_PIN_SS];
        spi_sck_in            = portb_pad_in[`PABM_PIN_SCK];
        spi_slave_in          = portb_pad_in[`PABM_PIN_MOSI];
        spi_master_in         = portb_pad_in[`PABM_PIN_MISO];
    end

    //--------------------------------------------------------------
    // SPI role status, registered for observation only
    //--------------------------------------------------------------
    always_comb begin
        case ({spi_is_master, spi_is_slave})
            2'b10:   next_spi_mode = pabm_pkg::PABM_SPI_MASTER;
            2'b01:   next_spi_mode = pabm_pkg::PABM_SPI_SLAVE;
            default: next_spi_mode = pabm_pkg::PABM_SPI_OFF;
        endcase
    end

    // Status register; overrides themselves never wait on it
    always_ff @(posedge clock) begin
        if (reset) begin
            spi_mode <= pabm_pkg::PABM_SPI_OFF;
        end else begin
            spi_mode <= next_spi_mode;
        end
    end
endmodule

//--- tb/pabm_mux_asserts.sv
// Checker for the port mux: override relations seen at the top ports.
// Assumes it is bound into every pabm_mux instance.
`timescale 1ns/1ps
module pabm_mux_chk (
    input wire logic                     clock,
    input wire logic                     reset,
    input wire logic                     display_drive_enable,
    input wire logic [3:1]               backplane_count_qualifier,
    input wire logic                     pull_disable,
    input wire logic                     sleeping,
    input wire logic [7:0]               porta_dir,
    input wire logic [7:0]               porta_pad_in,
    input wire logic [7:0]               portb_dir,
    input wire logic [7:0]               portb_out,
    input wire logic [7:0]               portb_pad_in,
    input wire logic                     t2_compare_a_en,
    input wire logic                     t2_compare_a_out,
    input wire logic                     spi_enable,
    input wire logic                     spi_master,
    input wire logic [7:0]               porta_drive_en,
    input wire logic [7:0]               porta_in_en,
    input wire logic [3:0]               segment_analog_path,
    input wire logic [7:0]               portb_drive_en,
    input wire logic [7:0]               portb_drive_val,
    input wire logic [7:0]               portb_pull_en,
    input wire logic [15:8]              pin_change_source,
    input wire logic                     spi_ss_in,
    input wire pabm_pkg::pabm_spi_mode_t spi_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Frontplane lines released when the display drives them
    property p_seg_off;
        display_drive_enable |-> (porta_drive_en[7:4] | porta_in_en[7:4]) == 4'h0;
    endproperty
    a_seg_off: assert property (p_seg_off) else $error("frontplane pin not released");
    property p_bp_gate;
        porta_drive_en[3:0] == (porta_dir[3:0]
            & ~({4{display_drive_enable}} & {backplane_count_qualifier, 1'b1}));
    endproperty
    a_bp_gate: assert property (p_bp_gate) else $error("backplane gating wrong");
    property p_in_norm;
        !display_drive_enable |-> porta_in_en == {8{!sleeping}};
    endproperty
    a_in_norm: assert property (p_in_norm) else $error("input enable ignores sleep");
    property p_analog;
        segment_analog_path == porta_pad_in[7:4];
    endproperty
    a_analog: assert property (p_analog) else $error("segment path not from pads");
    // Second port alternate functions
    property p_t2;
        t2_compare_a_en && portb_dir[7] |-> portb_drive_en[7]
            && portb_drive_val[7] == t2_compare_a_out;
    endproperty
    a_t2: assert property (p_t2) else $error("timer 2 output not on pin 7");
    property p_miso;
        spi_enable && spi_master |-> !portb_drive_en[3]
            && portb_pull_en[3] == (portb_out[3] && !pull_disable);
    endproperty
    a_miso: assert property (p_miso) else $error("master input pin not forced");
    property p_slave;
        spi_enable && !spi_master |-> portb_drive_en[2:1] == 2'h0;
    endproperty
    a_slave: assert property (p_slave) else $error("slave input pins driven");
    property p_pcint;
        pin_change_source == portb_pad_in && spi_ss_in == portb_pad_in[0];
    endproperty
    a_pcint: assert property (p_pcint) else $error("pin change map wrong");
    property p_mode;
        !spi_enable |=> spi_mode == pabm_pkg::PABM_SPI_OFF;
    endproperty
    a_mode: assert property (p_mode) else $error("mode not off after disable");
endmodule
bind pabm_mux pabm_mux_chk chk_u (.clock, .reset, .display_drive_enable,
    .backplane_count_qualifier, .pull_disable, .sleeping, .porta_dir, .porta_pad_in,
    .portb_dir, .portb_out, .portb_pad_in, .t2_compare_a_en, .t2_compare_a_out,
    .spi_enable, .spi_master, .porta_drive_en, .porta_in_en, .segment_analog_path,
    .portb_drive_en, .portb_drive_val, .portb_pull_en, .pin_change_source,
    .spi_ss_in, .spi_mode);

//--- tb/pabm_periph_model.sv
// Stand-in for timers, SPI and pads: output values and pad levels.
// Assumes one clock; every value derives from a counter stepping each cycle so stale data shows.
`timescale 1ns/1ps
module pabm_periph_model (
    input  wire logic       clock,
    input  wire logic       reset,
    output logic      [3:0] t_out,
    output logic      [2:0] spi_out,
    output logic      [7:0] pa_pad,
    output logic      [7:0] pb_pad
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    // Pattern counter
    always_comb begin
        next_cnt = reset ? 8'h00 : cnt + 8'h01;
    end
    always_ff @(posedge clock) begin
        cnt <= next_cnt;
    end
    // Values handed to the mux
    assign t_out   = cnt[3:0] ^ 4'h5;
    assign spi_out = cnt[6:4] ^ cnt[2:0];
    assign pa_pad  = cnt ^ 8'h3c;
    assign pb_pad  = {cnt[3:0], cnt[7:4]} ^ cnt;
endmodule

//--- tb/pabm_mux_tb_top.sv
// Bench for the port mux: scenarios on display, timer, SPI, pin change.
// Assumes the stand-in model supplies peripheral values and pad levels.
`timescale 1ns/1ps
module pabm_mux_tb_top;
    logic        clock, reset, display_drive_enable, pull_disable, sleeping;
    logic [3:1]  backplane_count_qualifier;
    logic [7:0]  porta_dir, porta_out, portb_dir, portb_out, pin_change_mask;
    logic        t2_compare_a_en, t1_compare_b_en, t1_compare_a_en, t0_compare_a_en;
    logic        spi_enable, spi_master, pin_change_group_en;
    wire         t2_compare_a_out, t1_compare_b_out, t1_compare_a_out, t0_compare_a_out;
    wire         spi_slave_out, spi_master_out, spi_sck_out;
    wire  [7:0]  porta_pad_in, portb_pad_in;
    logic [7:0]  porta_pull_en, porta_drive_en, porta_drive_val, porta_in_en;
    logic [7:0]  portb_pull_en, portb_drive_en, portb_drive_val, portb_in_en;
    logic [3:0]  segment_analog_path, backplane_analog_path;
    logic [15:8] pin_change_source;
    logic        spi_ss_in, spi_sck_in, spi_slave_in, spi_master_in;
    int          err_total = 0, compares = 0;
    pabm_pkg::pabm_spi_mode_t spi_mode;
    pabm_periph_model model_u (.clock, .reset, .pa_pad(porta_pad_in), .pb_pad(portb_pad_in),
        .t_out({t2_compare_a_out, t1_compare_b_out, t1_compare_a_out, t0_compare_a_out}),
        .spi_out({spi_slave_out, spi_master_out, spi_sck_out}));
    pabm_mux dut_u (.clock, .reset, .display_drive_enable, .backplane_count_qualifier,
        .pull_disable, .sleeping, .porta_dir, .porta_out, .portb_dir, .portb_out,
        .t2_compare_a_en, .t2_compare_a_out, .t1_compare_b_en, .t1_compare_b_out,
        .t1_compare_a_en, .t1_compare_a_out, .t0_compare_a_en, .t0_compare_a_out,
        .spi_enable, .spi_master, .spi_slave_out, .spi_master_out, .spi_sck_out,
        .pin_change_mask, .pin_change_group_en, .porta_pad_in, .portb_pad_in,
        .porta_pull_en, .porta_drive_en, .porta_drive_val, .porta_in_en,
        .segment_analog_path, .backplane_analog_path, .portb_pull_en, .portb_drive_en,
        .portb_drive_val, .portb_in_en, .pin_change_source, .spi_ss_in, .spi_sck_in,
        .spi_slave_in, .spi_master_in, .spi_mode);
    // Clock at 8 ns
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected pad controls worked out from the current inputs
    task automatic chk_all();
        logic [7:0] ov, de, dv, ten;
        ov  = display_drive_enable ? {4'hf, backplane_count_qualifier, 1'b1} : 8'h00;
        de  = porta_dir & ~ov;
        check(porta_drive_en, de);
        check(porta_pull_en, ~porta_dir & porta_out & ~ov & {8{!pull_disable}});
        check(porta_in_en, {8{!sleeping}} & ~ov);
        check(porta_drive_val & de, porta_out & de);
        check({segment_analog_path, backplane_analog_path}, porta_pad_in);
        de  = portb_dir & ~(!spi_enable ? 8'h00 : (spi_master ? 8'h08 : 8'h07));
        ten = {t2_compare_a_en, t1_compare_b_en, t1_compare_a_en, t0_compare_a_en, 4'h0};
        dv  = (portb_out & ~ten) | ({t2_compare_a_out, t1_compare_b_out,
            t1_compare_a_out, t0_compare_a_out, 4'h0} & ten);
        dv[3] = (spi_enable && !spi_master) ? spi_slave_out : dv[3];
        dv[2:1] = (spi_enable && spi_master) ? {spi_master_out, spi_sck_out} : dv[2:1];
        check(portb_drive_en, de);
        check(portb_pull_en, ~de & portb_out & {8{!pull_disable}});
        check(portb_drive_val & de, dv & de);
        check(portb_in_en, {8{!sleeping}} | (pin_change_mask & {8{pin_change_group_en}}));
        check(pin_change_source, portb_pad_in);
        check({spi_master_in, spi_slave_in, spi_sck_in, spi_ss_in}, portb_pad_in[3:0]);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_display();
        for (int i = 0; i < 32; i++) begin
            @(posedge clock);
            {pull_disable, backplane_count_qualifier, display_drive_enable} <= i[4:0];
            sleeping  <= i[2];
            porta_dir <= 8'h5a ^ 8'(i);
            porta_out <= 8'hc3 ^ 8'(i * 7);
            @(negedge clock);
            chk_all();
        end
    endtask
    task automatic sc_timer();
        for (int i = 0; i < 32; i++) begin
            @(posedge clock);
            {t2_compare_a_en, t1_compare_b_en, t1_compare_a_en, t0_compare_a_en} <= i[3:0];
            portb_dir <= i[4] ? 8'hf0 : {~i[3:0], 4'h0};
            portb_out <= 8'(i * 37);
            @(negedge clock);
            chk_all();
        end
    endtask
    task automatic sc_spi();
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            spi_enable   <= (i % 3) != 0;
            spi_master   <= (i % 3) == 2;
            portb_dir    <= i[2] ? 8'hff : 8'h00;
            portb_out    <= i[3] ? 8'h0f : 8'hf0;
            pull_disable <= i[0];
            @(negedge clock);
            chk_all();
            @(negedge clock);
            check(spi_mode, (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'h01 : 8'h03));
        end
    endtask
    task automatic sc_pcint();
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            sleeping            <= 1'b1;
            pin_change_group_en <= i != 9;
            pin_change_mask     <= (i < 8) ? 8'(1 << i) : 8'hff;
            @(negedge clock);
            chk_all();
        end
    endtask
    task automatic sc_reset();
        @(posedge clock);
        {spi_enable, spi_master, reset} <= 3'h7;
        @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check(spi_mode, 8'h00);
        @(negedge clock);
        check(spi_mode, 8'h03);
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {reset, display_drive_enable, pull_disable, sleeping, spi_enable, spi_master} = 6'h20;
        {backplane_count_qualifier, porta_dir, porta_out, portb_dir, portb_out} = '0;
        {t2_compare_a_en, t1_compare_b_en, t1_compare_a_en, t0_compare_a_en} = 4'h0;
        {pin_change_mask, pin_change_group_en} = '0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        sc_display();
        sc_timer();
        sc_spi();
        sc_pcint();
        sc_reset();
        end_of_test();
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        $display("BAD %0t run too long", $time);
        end_of_test();
    end
endmodule
